/* logic/hop_enc_consts.svh */
// Constants for the hopping encoder control and parameter store.
// Assumes inclusion by bare name from the design module.
`ifndef HOP_ENC_CONSTS_SVH
`define HOP_ENC_CONSTS_SVH
`define WORD_COUNT          12
`define ADDR_KEY0           4'h0
`define ADDR_KEY1           4'h1
`define ADDR_KEY2           4'h2
`define ADDR_KEY3           4'h3
`define ADDR_COUNTER        4'h4
`define ADDR_SPARE_A        4'h5
`define ADDR_UNIT_LO        4'h6
`define ADDR_UNIT_HI        4'h7
`define ADDR_LEARN_LO       4'h8
`define ADDR_LEARN_HI       4'h9
`define ADDR_SPARE_B        4'ha
`define ADDR_OPTION         4'hb
`define DISC_MSB            9
`define SENT_UNIT_HI_MSB    11
`define OPT_FIRST_WRAP      10
`define OPT_SECOND_WRAP     11
`define OPT_TRIP_SEL        12
`define OPT_RATE_LO         13
`define OPT_RATE_HI         14
`define UNIT_SHUTOFF_BIT    15
`define CLK_PERIOD_NS       10
`define NS_PER_MS           1000000
`define NS_PER_S            1000000000
`define DEBOUNCE_MS         10
`define SHUTOFF_S           25
`define ALL_BUTTONS         4'hf
`define NO_BUTTONS          4'h0
`define COUNT_ALL_ONES      16'hffff
`endif

/* logic/hop_enc_pkg.sv */
// Types shared by the hopping encoder control logic.
// Assumes hop_enc_consts.svh is on the include path.
package hop_enc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_DEBOUNCE = 3'b001,
      ST_UPDATE   = 3'b010,
      ST_CIPHER   = 3'b011,
      ST_SEND     = 3'b100,
      ST_TIMEOUT  = 3'b101
   } enc_state_t;
endpackage

/* logic/hop_enc_control.sv */
// Control and parameter store of a code-hopping keyless-entry encoder.
// Assumes: buttons are asynchronous pins; the cipher is an outside block with a
// start/done handshake; a serialiser drains 66-bit code words through a ready signal.
// Notes on behaviour
// - Button press wakes, debounces 10 ms, samples
// - Hopping part encrypts counter, discrimination, buttons
// - Added button aborts word, restarts with set
// - Released buttons ignored until none remain
// - Store is twelve sixteen-bit words
// - Fixed word map for key, counter, serial
// - Counter increments and is stored each hopping transmission, not for the seed
// - Only low 28 serial bits transmitted
// - All buttons send stored seed instead
// - Serial bit 31 enables auto-shutoff
// - Shutoff after 25 s pressing; stop sending
// - Option bits 0..9 hold discrimination
// - Option bits 10..14 flags, trip, rate
// - First wrap clears flag one, second clears two
// - Cleared wrap flags set again only by programming the option word
// - Fixed part: status, buttons, 28-bit serial
// - Encrypted input: buttons, 2 wrap flags, 10 discrimination, counter
// - Store writable, read back externally only as the verify of the word just written
`timescale 1ns/1ps
`include "hop_enc_consts.svh"
module hop_enc_control
   import hop_enc_pkg::*;
#(
   parameter int     DEBOUNCE_CYC = (`DEBOUNCE_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
   parameter longint SHUTOFF_CYC  = (longint'(`SHUTOFF_S) * `NS_PER_S) / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic          CLOCK,
   input  wire logic          SYS_RST,
   // Button pins
   input  wire logic          BUTTON_IN_0,
   input  wire logic          BUTTON_IN_1,
   input  wire logic          BUTTON_IN_2,
   input  wire logic          BUTTON_IN_3,
   // Programming write port
   input  wire logic          PROG_WE,
   input  wire logic [3:0]    PROG_ADDR,
   input  wire logic [15:0]   PROG_DATA,
   input  wire logic          VERIFY_RE,
   output logic      [15:0]   VERIFY_DATA,
   // Cipher engine
   output logic               CIPHER_START,
   output logic      [31:0]   CIPHER_PLAIN,
   output logic      [63:0]   CIPHER_SECRET,
   input  wire logic          CIPHER_DONE,
   input  wire logic [31:0]   CIPHER_RESULT,
   // Code word stream to serialiser
   output logic               WORD_VALID,
   output logic      [65:0]   WORD_DATA,
   input  wire logic          WORD_READY,
   output logic               WORD_ABORT,
   // Status
   input  wire logic          BATTERY_LOW,
   output logic               AWAKE,
   output logic               TIMED_OUT,
   output logic               BATTERY_TRIP_SELECT,
   output logic      [1:0]    RATE_SELECT
);
   initial begin
      if (DEBOUNCE_CYC < 2 || SHUTOFF_CYC < 1 || SHUTOFF_CYC > 64'hffffffff) begin
         $error("Timing counts out of range");
      end
   end

   // Parameter store; no external read path except the verify after a write
   logic [15:0] store_q [`WORD_COUNT];
   logic [15:0] verify_q;
   logic        verify_ok_q;

   function automatic logic addr_ok(input logic [3:0] a);
      addr_ok = (a < 4'(`WORD_COUNT));
   endfunction

   // Synchronised buttons
   logic [3:0] btn_s1_q, btn_s2_q;
   wire  [3:0] btn = btn_s2_q;
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         btn_s1_q <= 4'h0;
         btn_s2_q <= 4'h0;
      end else begin
         btn_s1_q <= {BUTTON_IN_3, BUTTON_IN_2, BUTTON_IN_1, BUTTON_IN_0};
         btn_s2_q <= btn_s1_q;
      end
   end

   enc_state_t   state_q;
   logic [3:0]   sampled_q;
   logic [31:0]  timer_q;
   logic [31:0]  press_q;
   logic         start_q;
   logic         repeat_q;

   wire [15:0] option   = store_q[`ADDR_OPTION];
   wire [15:0] unit_hi  = store_q[`ADDR_UNIT_HI];
   wire        shutoff_en = unit_hi[`UNIT_SHUTOFF_BIT];
   wire        added    = |(btn & ~sampled_q);
   wire        cnt_wrap = (store_q[`ADDR_COUNTER] == `COUNT_ALL_ONES);

   // Two-entry output buffer
   logic [65:0] buf_q [2];
   logic [1:0]  buf_cnt_q;
   logic        buf_rd_q, buf_wr_q;
   wire         buf_ready = (buf_cnt_q != 2'd2);
   wire         push = (state_q == ST_SEND) && !start_q && buf_ready && !added;
   wire         pop  = WORD_VALID && WORD_READY;
   logic [65:0] word_d;

   always_comb begin
      if (sampled_q == `ALL_BUTTONS) begin
         word_d = {2'b00, 32'h0, store_q[`ADDR_LEARN_HI], store_q[`ADDR_LEARN_LO]};
      end else begin
         word_d = {repeat_q, BATTERY_LOW, sampled_q, unit_hi[`SENT_UNIT_HI_MSB:0],
                   store_q[`ADDR_UNIT_LO], CIPHER_RESULT};
      end
   end

   // Control sequence
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         state_q   <= ST_IDLE;
         sampled_q <= 4'h0;
         timer_q   <= 32'h0;
         start_q   <= 1'b0;
         repeat_q  <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               repeat_q <= 1'b0;
               if (btn != `NO_BUTTONS) begin
                  timer_q <= 32'h0;
                  state_q <= ST_DEBOUNCE;
               end
            end
            ST_DEBOUNCE: begin
               timer_q <= timer_q + 32'h1;
               if (timer_q == 32'(DEBOUNCE_CYC - 1)) begin
                  sampled_q <= btn;
                  state_q   <= (btn == `NO_BUTTONS) ? ST_IDLE : ST_UPDATE;
               end
            end
            ST_UPDATE: begin
               state_q <= (sampled_q == `ALL_BUTTONS) ? ST_SEND : ST_CIPHER;
            end
            ST_CIPHER: begin
               if (added) begin
                  sampled_q <= sampled_q | btn;
                  repeat_q  <= 1'b0;
                  state_q   <= ST_UPDATE;
               // A done in the start cycle belongs to an abandoned word
               end else if (CIPHER_DONE && !start_q) begin
                  state_q <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (added) begin
                  sampled_q <= sampled_q | btn;
                  repeat_q  <= 1'b0;
                  state_q   <= ST_UPDATE;
               end else if (push) begin
                  if (btn == `NO_BUTTONS) begin
                     state_q <= ST_IDLE;
                  end else if (shutoff_en && press_q >= 32'(SHUTOFF_CYC - 1)) begin
                     state_q <= ST_TIMEOUT;
                  end else begin
                     repeat_q <= 1'b1;
                     state_q  <= ST_UPDATE;
                  end
               end
            end
            ST_TIMEOUT: begin
               if (btn == `NO_BUTTONS) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         if (state_q == ST_UPDATE && sampled_q != `ALL_BUTTONS) begin
            start_q <= 1'b1;
         end
      end
   end

   // Continuous press time for auto-shutoff
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || state_q == ST_IDLE) begin
         press_q <= 32'h0;
      end else if (press_q != 32'hffffffff) begin
         press_q <= press_q + 32'h1;
      end
   end

   // Store writes; the counter update wins over programming in the same cycle
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         verify_q    <= 16'h0;
         verify_ok_q <= 1'b0;
      end else begin
         verify_ok_q <= 1'b0;
         if (state_q == ST_UPDATE && sampled_q != `ALL_BUTTONS) begin
            store_q[`ADDR_COUNTER] <= store_q[`ADDR_COUNTER] + 16'h1;
            if (cnt_wrap) begin
               if (option[`OPT_FIRST_WRAP]) begin
                  store_q[`ADDR_OPTION][`OPT_FIRST_WRAP] <= 1'b0;
               end else begin
                  store_q[`ADDR_OPTION][`OPT_SECOND_WRAP] <= 1'b0;
               end
            end
         end else if (PROG_WE && addr_ok(PROG_ADDR) && state_q == ST_IDLE) begin
            store_q[PROG_ADDR] <= PROG_DATA;
            verify_q    <= PROG_DATA;
            verify_ok_q <= 1'b1;
         end
      end
   end

   // Verify only returns the word just written
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         VERIFY_DATA <= 16'h0;
      end else begin
         VERIFY_DATA <= (VERIFY_RE && verify_ok_q) ? verify_q : 16'h0;
      end
   end

   // Buffer
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || WORD_ABORT) begin
         buf_cnt_q <= 2'd0;
         buf_rd_q  <= 1'b0;
         buf_wr_q  <= 1'b0;
      end else begin
         if (push) begin
            buf_q[buf_wr_q] <= word_d;
            buf_wr_q        <= !buf_wr_q;
         end
         if (pop) begin
            buf_rd_q <= !buf_rd_q;
         end
         buf_cnt_q <= buf_cnt_q + 2'(push) - 2'(pop);
      end
   end

   assign WORD_VALID    = (buf_cnt_q != 2'd0);
   assign WORD_DATA     = buf_q[buf_rd_q];
   assign WORD_ABORT    = (state_q == ST_SEND || state_q == ST_CIPHER) && added;
   assign CIPHER_START  = start_q;
   assign CIPHER_PLAIN  = {sampled_q, option[`OPT_SECOND_WRAP:`OPT_FIRST_WRAP], option[`DISC_MSB:0],
                           store_q[`ADDR_COUNTER]};
   assign CIPHER_SECRET = {store_q[`ADDR_KEY3], store_q[`ADDR_KEY2], store_q[`ADDR_KEY1], store_q[`ADDR_KEY0]};
   assign AWAKE         = (state_q != ST_IDLE);
   assign TIMED_OUT     = (state_q == ST_TIMEOUT);
   assign BATTERY_TRIP_SELECT = option[`OPT_TRIP_SEL];
   assign RATE_SELECT   = {option[`OPT_RATE_HI], option[`OPT_RATE_LO]};

   a_counter_step: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (state_q == ST_UPDATE && sampled_q != `ALL_BUTTONS && !PROG_WE)
      |=> store_q[`ADDR_COUNTER] == $past(store_q[`ADDR_COUNTER]) + 16'h1)
      else $error("Counter did not advance");
   a_flag_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (!option[`OPT_FIRST_WRAP] && state_q != ST_IDLE) |=> !option[`OPT_FIRST_WRAP])
      else $error("Wrap flag set again");
   a_abort_restart: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      WORD_ABORT |=> state_q == ST_UPDATE && WORD_VALID == 1'b0)
      else $error("Abort did not restart");
   a_seed_word: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (push && sampled_q == `ALL_BUTTONS) |-> word_d == {2'b00, 32'h0, store_q[`ADDR_LEARN_HI],
      store_q[`ADDR_LEARN_LO]})
      else $error("Seed not sent");
   a_no_start_seed: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      CIPHER_START |-> sampled_q != `ALL_BUTTONS && state_q == ST_CIPHER)
      else $error("Cipher start misplaced");
   a_timeout_quiet: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      state_q == ST_TIMEOUT |=> !CIPHER_START && (state_q == ST_TIMEOUT || state_q == ST_IDLE))
      else $error("Sending in time-out");
   a_debounce_wait: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (state_q == ST_IDLE && btn != `NO_BUTTONS) |=> state_q == ST_DEBOUNCE [*2])
      else $error("Debounce skipped");
   a_serial_trim: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (push && sampled_q != `ALL_BUTTONS) |-> word_d[59:32] == {unit_hi[11:0], store_q[`ADDR_UNIT_LO]})
      else $error("Serial field wrong");
   a_flag_two_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (!option[`OPT_SECOND_WRAP] && state_q != ST_IDLE) |=> !option[`OPT_SECOND_WRAP])
      else $error("Second wrap flag set again");
   a_wrap_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (state_q == ST_UPDATE && sampled_q != `ALL_BUTTONS && cnt_wrap && option[`OPT_FIRST_WRAP])
      |=> !option[`OPT_FIRST_WRAP] && option[`OPT_SECOND_WRAP] == $past(option[`OPT_SECOND_WRAP]))
      else $error("First wrap did not clear flag one");
   a_verify_idle: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      !verify_ok_q |=> VERIFY_DATA == 16'h0)
      else $error("Store read back outside verify");
   a_word_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (WORD_VALID && !WORD_READY && !WORD_ABORT) |=> WORD_VALID && $stable(WORD_DATA))
      else $error("Offered word changed before taken");
   a_restart_fresh: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      WORD_ABORT |=> !repeat_q)
      else $error("Restart kept repeat flag");
endmodule

/* bench/hop_word_sink.sv */
// Model of the transmitter stage that drains code words from the encoder.
// Assumes the encoder's clock; stall and slow pacing are set by the bench.
`timescale 1ns/1ps
module hop_word_sink (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Word stream
   input  wire logic        valid,
   input  wire logic [65:0] data,
   output logic             ready,
   // Pacing
   input  wire logic        stall,
   input  wire logic        slow
);
   logic [65:0] q[$];
   logic        tick_q;
   always @(posedge clk) begin
      tick_q <= rst ? 1'b0 : ~tick_q;
      if (!rst && valid && ready) begin
         q.push_back(data);
      end
   end
   // Slow pacing takes at most every other word slot, to exercise the buffer
   assign ready = !rst && !stall && (!slow || tick_q);
endmodule

/* bench/hop_enc_control_tb.sv */
// Self-checking bench for the encoder control and parameter store.
// Assumes a fast cipher stand-in here and the word sink model beside the encoder.
`timescale 1ns/1ps
module hop_enc_control_tb;
   localparam logic [15:0] K0 = 16'h1a2b, K1 = 16'h3c4d, K2 = 16'h5e6f, K3 = 16'h7081;
   localparam logic [15:0] ULO = 16'h5678, UHI = 16'h8123, OPT = 16'h5e78;
   logic CLOCK = 0, SYS_RST = 1, PROG_WE = 0, VERIFY_RE = 0, CIPHER_DONE = 0, BATTERY_LOW = 0;
   logic stall = 0, slow = 0;
   logic [3:0]  btn = 4'h0, prog_addr = 4'h0;
   logic [15:0] prog_data = 16'h0;
   logic [31:0] cres = 32'h0;
   logic [2:0]  cdly = 3'h0;
   logic [15:0] img [12];
   logic [65:0] w;
   wire logic CIPHER_START, WORD_VALID, WORD_READY, WORD_ABORT, AWAKE, TIMED_OUT, BATTERY_TRIP_SELECT;
   wire logic [31:0] CIPHER_PLAIN;
   wire logic [63:0] CIPHER_SECRET;
   wire logic [65:0] WORD_DATA;
   wire logic [1:0]  RATE_SELECT;
   wire logic [15:0] VERIFY_DATA;
   int fail_count = 0, checks = 0, n_start = 0, n_abort = 0, n0, i;
   always #5 CLOCK = ~CLOCK;
   hop_enc_control #(.DEBOUNCE_CYC(20), .SHUTOFF_CYC(200)) u_dut (
      .CLOCK(CLOCK), .SYS_RST(SYS_RST),
      .BUTTON_IN_0(btn[0]), .BUTTON_IN_1(btn[1]), .BUTTON_IN_2(btn[2]), .BUTTON_IN_3(btn[3]),
      .PROG_WE(PROG_WE), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
      .VERIFY_RE(VERIFY_RE), .VERIFY_DATA(VERIFY_DATA),
      .CIPHER_START(CIPHER_START), .CIPHER_PLAIN(CIPHER_PLAIN), .CIPHER_SECRET(CIPHER_SECRET),
      .CIPHER_DONE(CIPHER_DONE), .CIPHER_RESULT(cres),
      .WORD_VALID(WORD_VALID), .WORD_DATA(WORD_DATA), .WORD_READY(WORD_READY), .WORD_ABORT(WORD_ABORT),
      .BATTERY_LOW(BATTERY_LOW), .AWAKE(AWAKE), .TIMED_OUT(TIMED_OUT),
      .BATTERY_TRIP_SELECT(BATTERY_TRIP_SELECT), .RATE_SELECT(RATE_SELECT));
   hop_word_sink u_sink (.clk(CLOCK), .rst(SYS_RST), .valid(WORD_VALID), .data(WORD_DATA),
      .ready(WORD_READY), .stall(stall), .slow(slow));
   // Cipher stand-in: key word order matters, so a swapped secret shows in the hop
   always @(posedge CLOCK) begin
      CIPHER_DONE <= (cdly == 3'd1);
      if (CIPHER_START) begin
         cdly <= 3'd3;
         cres <= (CIPHER_PLAIN ^ CIPHER_SECRET[31:0]) + CIPHER_SECRET[63:32];
         n_start++;
      end else if (cdly != 3'd0) begin
         cdly <= cdly - 3'd1;
      end
      if (WORD_ABORT) n_abort++;
   end
   function automatic logic [65:0] ew(logic r, logic [3:0] b, logic [15:0] c, logic [1:0] f);
      logic [31:0] p;
      p = {b, f, OPT[9:0], c};
      return {r, 1'b0, b, UHI[11:0], ULO, (p ^ {K1, K0}) + {K3, K2}};
   endfunction
   task chk(input logic [65:0] seen, input logic [65:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s", $time, what);
      end
   endtask
   task prog(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      PROG_WE <= 1'b1;
      prog_addr <= a;
      prog_data <= d;
      @(posedge CLOCK);
      PROG_WE <= 1'b0;
      repeat (2) @(posedge CLOCK);
      chk(VERIFY_DATA, d, "verify after write");
      @(posedge CLOCK);
      chk(VERIFY_DATA, 16'h0, "no read-back");
   endtask
   task press(input logic [3:0] b);
      @(posedge CLOCK);
      btn <= b;
   endtask
   task get();
      int n;
      n = 0;
      while (u_sink.q.size() == 0 && n < 3000) begin
         @(posedge CLOCK);
         n++;
      end
      w = (n < 3000) ? u_sink.q.pop_front() : 'x;
   endtask
   // Release all, let buffered words drain, then forget them
   task idle(input string name);
      int n;
      press(4'h0);
      for (n = 0; n < 3000 && AWAKE !== 1'b0; n++) @(posedge CLOCK);
      chk(AWAKE, 1'b0, "sleep");
      repeat (8) @(posedge CLOCK);
      u_sink.q.delete();
      $display("Test %s done", name);
   endtask
   task report_and_stop();
      $display("Counts: checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      report_and_stop();
   end
   initial begin
      img = '{K0, K1, K2, K3, 16'hfffe, 16'h0, ULO, UHI, 16'hbeef, 16'hcafe, 16'h0, OPT};
      repeat (16) @(posedge CLOCK);
      SYS_RST <= 1'b0;
      VERIFY_RE <= 1'b1;
      for (i = 0; i < 12; i++) prog(i[3:0], img[i]);
      repeat (2) @(posedge CLOCK);
      chk(BATTERY_TRIP_SELECT, 1'b1, "trip select");
      chk(RATE_SELECT, 2'b10, "rate select");
      press(4'hf);
      get();
      chk(w, {2'b00, 32'h0, 16'hcafe, 16'hbeef}, "seed word");
      idle("seed");
      n0 = n_start;
      press(4'h1);
      repeat (20) @(posedge CLOCK);
      chk(n_start == n0, 1'b1, "debounce wait");
      chk(AWAKE, 1'b1, "wake");
      get();
      chk(w, ew(1'b0, 4'h1, 16'hffff, 2'b11), "first word");
      get();
      chk(w, ew(1'b1, 4'h1, 16'h0000, 2'b10), "first wrap");
      idle("wrap one");
      prog(4'h4, 16'hffff);
      press(4'h1);
      get();
      chk(w, ew(1'b0, 4'h1, 16'h0000, 2'b00), "second wrap");
      idle("wrap two");
      stall <= 1'b1;
      BATTERY_LOW <= 1'b1;
      press(4'h1);
      repeat (40) @(posedge CLOCK);
      n0 = n_abort;
      press(4'h3);
      repeat (6) @(posedge CLOCK);
      chk(n_abort != n0, 1'b1, "abort on added button");
      stall <= 1'b0;
      get();
      chk(w[65:32], {1'b0, 1'b1, 4'h3, UHI[11:0], ULO}, "restart word");
      stall <= 1'b1;
      n0 = n_abort;
      press(4'h1);
      repeat (6) @(posedge CLOCK);
      stall <= 1'b0;
      get();
      chk(w[63:60], 4'h3, "partial release");
      chk(n_abort == n0, 1'b1, "no abort on release");
      BATTERY_LOW <= 1'b0;
      idle("abort");
      slow <= 1'b1;
      press(4'h4);
      for (i = 0; i < 600 && TIMED_OUT !== 1'b1; i++) @(posedge CLOCK);
      chk(TIMED_OUT, 1'b1, "shutoff");
      repeat (10) @(posedge CLOCK);
      u_sink.q.delete();
      repeat (30) @(posedge CLOCK);
      chk(u_sink.q.size() == 0, 1'b1, "silent after shutoff");
      idle("shutoff");
      prog(4'h7, UHI & 16'h7fff);
      press(4'h4);
      repeat (400) @(posedge CLOCK);
      chk(TIMED_OUT, 1'b0, "shutoff disabled");
      idle("no shutoff");
      report_and_stop();
   end
endmodule
